//--- src/timer_pwm_defines.svh
// Offsets, field positions, reset values and counts of the timer/PWM unit.
// Assumes an 8-bit register port with a 3-bit byte address.
`ifndef TIMER_PWM_DEFINES_SVH
`define TIMER_PWM_DEFINES_SVH

`define ADDR_W 3
`define OFF_TSC 3'h0
`define OFF_CNT_HI 3'h1
`define OFF_CNT_LO 3'h2
`define OFF_MOD_HI 3'h3
`define OFF_MOD_LO 3'h4
`define OFF_CSC 3'h5
`define OFF_CV_HI 3'h6
`define OFF_CV_LO 3'h7

`define TSC_PS_LSB 0
`define TSC_CLK_LSB 3
`define TSC_CPWM_BIT 5
`define CSC_MODE_LSB 0
`define CSC_ACT_LSB 2

`define TSC_RST 6'h00
`define CSC_RST 4'h0
`define MOD_RST 16'h0000
`define ALL_ONES 16'hFFFF
`define PRESC_W 7

`endif

//--- src/timer_pwm_pkg.sv
// Types of the timer/PWM unit: channel modes and the packed state record.
// Assumes the constants header is compiled alongside.
package timer_pwm_pkg;

    typedef enum logic [1:0] {
        MODE_CAPTURE = 2'h0,
        MODE_COMPARE = 2'h1,
        MODE_EDGE_PWM = 2'h3,
        MODE_CENTER_PWM = 2'h2
    } chan_mode_t;

    typedef struct packed {
        logic [5:0] tsc;
        logic [3:0] csc;
        logic [15:0] cnt;
        logic [6:0] presc;
        logic down;
        logic [15:0] modv;
        logic [7:0] mod_buf;
        logic mod_pend;
        logic [15:0] cv;
        logic [15:0] cv_buf;
        logic cv_hi_got;
        logic cv_lo_got;
        logic [7:0] cnt_lat;
        logic cnt_latf;
        logic [7:0] cv_lat;
        logic cv_latf;
        logic out;
        logic oe;
        logic cap_s1;
        logic cap_s2;
        logic cap_prev;
        logic [7:0] rdata;
    } state_t;

endpackage

//--- src/timer_pwm_buffered_update.sv
// One-channel 16-bit timer/PWM with buffered value updates and byte-pair
// read coherency. Assumes a same-clock byte register port and a
// debug_halt level from the processor on core_clk.
//
// Our own choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`include "timer_pwm_defines.svh"

module timer_pwm_buffered_update (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [`ADDR_W-1:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [7:0] rdata,
    input wire logic debug_halt,
    input wire logic chan_in,
    output logic chan_out,
    output logic chan_oe
);
    import timer_pwm_pkg::*;

    state_t state_reg;
    state_t state_next;

    function automatic logic hit(input logic stb, input logic [`ADDR_W-1:0] a,
                                 input logic [`ADDR_W-1:0] off);
        hit = stb && (a == off);
    endfunction

    logic [2:0] ps;
    logic [1:0] clk_sel;
    logic cpwm;
    chan_mode_t mode;
    logic [15:0] top;
    logic [6:0] presc_mask;
    logic tick;
    logic load_evt;
    logic cv_pair;

    assign ps = state_reg.tsc[`TSC_PS_LSB +: 3];
    assign clk_sel = state_reg.tsc[`TSC_CLK_LSB +: 2];
    assign cpwm = state_reg.tsc[`TSC_CPWM_BIT];
    assign mode = cpwm ? MODE_CENTER_PWM : chan_mode_t'(state_reg.csc[`CSC_MODE_LSB +: 2]);
    // A modulo of zero or all-ones lets the counter span the full range.
    assign top = (state_reg.modv == 16'h0000 || state_reg.modv == `ALL_ONES)
               ? `ALL_ONES : state_reg.modv;
    assign presc_mask = 7'((8'h01 << ps) - 8'h01);
    assign tick = (clk_sel != 2'h0) && !debug_halt
                && (state_reg.presc == presc_mask);
    // Up-count step onto the top value; FFFE to FFFF when free running.
    assign load_evt = tick && !state_reg.down
                    && (state_reg.cnt == top - 16'h0001);
    assign cv_pair = state_reg.cv_hi_got && state_reg.cv_lo_got;

    always_comb begin
        logic active;
        logic cap_edge;
        active = 1'b0;
        cap_edge = 1'b0;
        state_next = state_reg;

        // Input synchroniser for the channel pin.
        state_next.cap_s1 = chan_in;
        state_next.cap_s2 = state_reg.cap_s1;
        state_next.cap_prev = state_reg.cap_s2;

        if (clk_sel != 2'h0 && !debug_halt) begin
            state_next.presc = tick ? '0 : state_reg.presc + 7'h01;
        end

        if (tick) begin
            if (cpwm) begin
                if (state_reg.down) begin
                    if (state_reg.cnt == 16'h0000) begin
                        state_next.down = 1'b0;
                        state_next.cnt = 16'h0001;
                    end else begin
                        state_next.cnt = state_reg.cnt - 16'h0001;
                    end
                end else if (state_reg.cnt >= top) begin
                    state_next.down = 1'b1;
                    state_next.cnt = state_reg.cnt - 16'h0001;
                end else begin
                    state_next.cnt = state_reg.cnt + 16'h0001;
                end
            end else begin
                state_next.down = 1'b0;
                state_next.cnt = (state_reg.cnt >= top) ? 16'h0000
                               : state_reg.cnt + 16'h0001;
            end
        end

        // Buffered transfer into the active channel value.
        if (cv_pair) begin
            if (clk_sel == 2'h0) begin
                state_next.cv = state_reg.cv_buf;
                state_next.cv_hi_got = 1'b0;
                state_next.cv_lo_got = 1'b0;
            end else if ((mode == MODE_COMPARE && tick) ||
                         (mode != MODE_COMPARE && mode != MODE_CAPTURE && load_evt)) begin
                // Compare mode transfers on any counter step; PWM modes transfer only at the top, which keeps a period whole.
                state_next.cv = state_reg.cv_buf;
                state_next.cv_hi_got = 1'b0;
                state_next.cv_lo_got = 1'b0;
            end
        end

        cap_edge = state_reg.cap_s2 != state_reg.cap_prev;
        if (mode == MODE_CAPTURE && cap_edge) begin
            case (state_reg.csc[`CSC_ACT_LSB +: 2])
                2'h1: if (state_reg.cap_s2) state_next.cv = state_reg.cnt;
                2'h2: if (!state_reg.cap_s2) state_next.cv = state_reg.cnt;
                2'h3: state_next.cv = state_reg.cnt;
                default: ;
            endcase
        end

        // Output update on each counter step.
        if (tick) begin
            case (mode)
                MODE_COMPARE: begin
                    if (state_next.cnt == state_next.cv) begin
                        case (state_reg.csc[`CSC_ACT_LSB +: 2])
                            2'h1: state_next.out = !state_reg.out;
                            2'h2: state_next.out = 1'b0;
                            2'h3: state_next.out = 1'b1;
                            default: ;
                        endcase
                    end
                end
                MODE_EDGE_PWM: begin
                    active = (state_next.cv > top) || (state_next.cnt < state_next.cv);
                    state_next.out = state_reg.csc[`CSC_ACT_LSB] ? active : !active;
                end
                MODE_CENTER_PWM: begin
                    active = (state_next.cv == top)
                           || (state_next.cnt < state_next.cv)
                           || (state_next.cnt == state_next.cv && state_next.down);
                    state_next.out = state_reg.csc[`CSC_ACT_LSB] ? active : !active;
                end
                default: ;
            endcase
        end
        state_next.oe = (mode != MODE_CAPTURE);

        // Register writes.
        if (hit(wr_stb, addr, `OFF_TSC)) begin
            state_next.tsc = wdata[5:0];
            if (debug_halt) begin
                state_next.cnt_latf = 1'b0;
                state_next.mod_pend = 1'b0;
            end
        end
        if (hit(wr_stb, addr, `OFF_CNT_HI) || hit(wr_stb, addr, `OFF_CNT_LO)) begin
            state_next.cnt = 16'h0000;
            state_next.presc = '0;
            state_next.down = 1'b0;
            state_next.cnt_latf = 1'b0;
        end
        if (hit(wr_stb, addr, `OFF_MOD_HI)) begin
            state_next.mod_buf = wdata;
            state_next.mod_pend = 1'b1;
        end
        if (hit(wr_stb, addr, `OFF_MOD_LO) && state_reg.mod_pend) begin
            state_next.modv = {state_reg.mod_buf, wdata};
            state_next.mod_pend = 1'b0;
        end
        if (hit(wr_stb, addr, `OFF_CSC)) begin
            state_next.csc = wdata[3:0];
            if (debug_halt) begin
                state_next.cv_latf = 1'b0;
            end
        end
        if (mode != MODE_CAPTURE) begin
            if (hit(wr_stb, addr, `OFF_CV_HI)) begin
                state_next.cv_buf[15:8] = wdata;
                state_next.cv_hi_got = 1'b1;
            end
            if (hit(wr_stb, addr, `OFF_CV_LO)) begin
                state_next.cv_buf[7:0] = wdata;
                state_next.cv_lo_got = 1'b1;
            end
        end

        // Register reads; data stands in the following cycle.
        if (rd_stb) begin
            case (addr)
                `OFF_TSC: state_next.rdata = {2'h0, state_reg.tsc};
                `OFF_CNT_HI, `OFF_CNT_LO: begin
                    if (debug_halt) begin
                        state_next.rdata = (addr == `OFF_CNT_HI) ? state_reg.cnt[15:8]
                                         : state_reg.cnt[7:0];
                    end else if (state_reg.cnt_latf) begin
                        state_next.rdata = state_reg.cnt_lat;
                        state_next.cnt_latf = 1'b0;
                    end else begin
                        state_next.rdata = (addr == `OFF_CNT_HI) ? state_reg.cnt[15:8]
                                         : state_reg.cnt[7:0];
                        state_next.cnt_lat = (addr == `OFF_CNT_HI) ? state_reg.cnt[7:0]
                                           : state_reg.cnt[15:8];
                        state_next.cnt_latf = 1'b1;
                    end
                end
                `OFF_MOD_HI: state_next.rdata = state_reg.modv[15:8];
                `OFF_MOD_LO: state_next.rdata = state_reg.modv[7:0];
                `OFF_CSC: state_next.rdata = {4'h0, state_reg.csc};
                default: begin
                    if (debug_halt) begin
                        state_next.rdata = (addr == `OFF_CV_HI) ? state_reg.cv[15:8]
                                         : state_reg.cv[7:0];
                    end else if (state_reg.cv_latf) begin
                        state_next.rdata = state_reg.cv_lat;
                        state_next.cv_latf = 1'b0;
                    end else begin
                        state_next.rdata = (addr == `OFF_CV_HI) ? state_reg.cv[15:8]
                                         : state_reg.cv[7:0];
                        state_next.cv_lat = (addr == `OFF_CV_HI) ? state_reg.cv[7:0]
                                          : state_reg.cv[15:8];
                        state_next.cv_latf = 1'b1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign rdata = state_reg.rdata;
    assign chan_out = state_reg.out;
    assign chan_oe = state_reg.oe;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    logic cnt_wr;
    assign cnt_wr = hit(wr_stb, addr, `OFF_CNT_HI) || hit(wr_stb, addr, `OFF_CNT_LO);

    property p_cnt_clear;
        cnt_wr |=> (state_reg.cnt == 16'h0000) && (state_reg.presc == '0);
    endproperty
    a_cnt_clear: assert property (p_cnt_clear) else $error("Counter write did not clear.");

    property p_halt_freeze;
        debug_halt && !cnt_wr |=> $stable(state_reg.cnt);
    endproperty
    a_halt_freeze: assert property (p_halt_freeze) else $error("Counter moved in halt.");

    sequence s_dbg_cnt_rd;
        debug_halt && hit(rd_stb, addr, `OFF_CNT_LO);
    endsequence
    property p_dbg_cnt_rd;
        s_dbg_cnt_rd |=> rdata == $past(state_reg.cnt[7:0]);
    endproperty
    a_dbg_cnt_rd: assert property (p_dbg_cnt_rd) else $error("Halt read not live count.");

    property p_dbg_cv_rd;
        debug_halt && hit(rd_stb, addr, `OFF_CV_HI) |=> rdata == $past(state_reg.cv[15:8]);
    endproperty
    a_dbg_cv_rd: assert property (p_dbg_cv_rd) else $error("Halt read not live value.");

    property p_dbg_tsc_clr;
        debug_halt && hit(wr_stb, addr, `OFF_TSC) |=> !state_reg.cnt_latf && !state_reg.mod_pend;
    endproperty
    a_dbg_tsc_clr: assert property (p_dbg_tsc_clr) else $error("Control write kept pairing.");

    property p_dbg_csc_clr;
        debug_halt && hit(wr_stb, addr, `OFF_CSC) |=> !state_reg.cv_latf;
    endproperty
    a_dbg_csc_clr: assert property (p_dbg_csc_clr) else $error("Channel latch not cleared.");

    property p_cap_block;
        mode == MODE_CAPTURE |=> $stable(state_reg.cv_buf);
    endproperty
    a_cap_block: assert property (p_cap_block) else $error("Capture mode took a write.");

    property p_pwm_load;
        (mode == MODE_EDGE_PWM || mode == MODE_CENTER_PWM) && clk_sel != 2'h0
            && !$stable(state_next.cv) |-> load_evt;
    endproperty
    a_pwm_load: assert property (p_pwm_load) else $error("Value loaded off the top step.");

    sequence s_center_full;
        tick && mode == MODE_CENTER_PWM && state_next.cv == top && state_reg.csc[`CSC_ACT_LSB];
    endsequence
    property p_center_full;
        s_center_full |=> chan_out;
    endproperty
    a_center_full: assert property (p_center_full) else $error("Full duty not held.");

    property p_pair_needed;
        !state_reg.cv_hi_got |=> $stable(state_reg.cv) || mode == MODE_CAPTURE;
    endproperty
    a_pair_needed: assert property (p_pair_needed) else $error("Value moved without pair.");

endmodule

//--- dv/timer_pwm_buffered_update_test.sv
// Self-checking bench for the buffered-update timer/PWM block.
// Assumes the constants header and the package are compiled first.
`timescale 1ns/1ps
`include "timer_pwm_defines.svh"

module timer_pwm_buffered_update_test;
    import timer_pwm_pkg::*;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic [`ADDR_W-1:0] addr = '0;
    logic [7:0] wdata = 8'h00;
    logic wr_stb = 1'b0;
    logic rd_stb = 1'b0;
    logic debug_halt = 1'b0;
    logic chan_in = 1'b0;
    logic [7:0] rdata;
    logic chan_out;
    logic chan_oe;
    logic [7:0] exp_q[$];
    int n_fail = 0;
    int tests_run = 0;
    int ones;
    logic [15:0] rng = 16'h0050;
    logic [15:0] cur;
    logic [15:0] nv;

    timer_pwm_buffered_update dut (
        .core_clk(core_clk),
        .nrst(nrst),
        .addr(addr),
        .wdata(wdata),
        .wr_stb(wr_stb),
        .rd_stb(rd_stb),
        .rdata(rdata),
        .debug_halt(debug_halt),
        .chan_in(chan_in),
        .chan_out(chan_out),
        .chan_oe(chan_oe)
    );

    initial begin
        forever #20 core_clk = ~core_clk;
    end

    function automatic logic [15:0] xs(input logic [15:0] s);
        logic [15:0] t;
        t = s ^ (s << 7);
        t = t ^ (t >> 9);
        return t ^ (t << 8);
    endfunction

    task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic results;
        $display("Checks run %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Read data stand from the cycle after the strobe until the next read, and are taken in that first cycle.
    always @(posedge core_clk) begin
        if (rd_stb === 1'b1) begin
            #1;
            if (exp_q.size() == 0) begin
                check8("unexpected rdata", 8'h00, 8'hXX);
            end else begin
                check8("rdata", exp_q.pop_front(), rdata);
            end
        end
    end

    task automatic wr(input logic [`ADDR_W-1:0] a, input logic [7:0] d);
        @(posedge core_clk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge core_clk);
        wr_stb <= 1'b0;
    endtask

    task automatic rd(input logic [`ADDR_W-1:0] a, input logic [7:0] e);
        @(posedge core_clk);
        addr <= a;
        rd_stb <= 1'b1;
        exp_q.push_back(e);
        @(posedge core_clk);
        rd_stb <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic wr16(input logic [`ADDR_W-1:0] a, input logic [15:0] v);
        wr(a, v[15:8]);
        wr(a + 3'h1, v[7:0]);
    endtask

    task automatic rd16(input logic [`ADDR_W-1:0] a, input logic [15:0] v);
        rd(a, v[15:8]);
        rd(a + 3'h1, v[7:0]);
    endtask

    task automatic halt(input logic b);
        @(posedge core_clk);
        debug_halt <= b;
    endtask

    // A center-aligned period with modulo 0x40 is 128 cycles long.
    task automatic duty(input logic [15:0] v, input int lo, input int hi);
        wr16(`OFF_CV_HI, v);
        repeat (200) @(posedge core_clk);
        ones = 0;
        repeat (128) begin
            @(posedge core_clk);
            #1;
            ones += (chan_out === 1'b1) ? 1 : 0;
        end
        tests_run++;
        if (ones < lo || ones > hi) begin
            n_fail++;
            $display("ERROR duty expected %0d to %0d seen %0d", lo, hi, ones);
        end
    endtask

    initial begin
        repeat (100000) @(posedge core_clk);
        n_fail++;
        $display("ERROR watchdog expected end seen none");
        results();
    end

    initial begin
        repeat (19) @(posedge core_clk);
        #1;
        check8("rdata", 8'h00, rdata);
        check8("chan_out", 8'h00, {7'h00, chan_out});
        check8("chan_oe", 8'h00, {7'h00, chan_oe});
        @(posedge core_clk);
        nrst <= 1'b1;
        rng = xs(rng);
        wr16(`OFF_CV_HI, rng);
        rd16(`OFF_CV_HI, 16'h0000);
        wr(`OFF_CSC, 8'h01);
        rng = xs(rng);
        wr16(`OFF_CV_HI, rng);
        rd16(`OFF_CV_HI, rng);
        wr(`OFF_CV_HI, ~rng[15:8]);
        rd16(`OFF_CV_HI, rng);
        wr(`OFF_CV_LO, 8'h5A);
        cur = {~rng[15:8], 8'h5A};
        rd16(`OFF_CV_HI, cur);
        rd(`OFF_CV_HI, cur[15:8]);
        halt(1'b1);
        rng = xs(rng);
        wr16(`OFF_CV_HI, rng);
        rd(`OFF_CV_LO, rng[7:0]);
        rd(`OFF_CV_HI, rng[15:8]);
        halt(1'b0);
        // Halt reads leave the earlier latch alone, so it still holds the old low byte.
        rd(`OFF_CV_HI, 8'h5A);
        rd(`OFF_CV_HI, rng[15:8]);
        halt(1'b1);
        cur = xs(rng);
        wr16(`OFF_CV_HI, cur);
        wr(`OFF_CSC, 8'h01);
        halt(1'b0);
        rd(`OFF_CV_LO, cur[7:0]);
        rd(`OFF_CV_HI, cur[15:8]);
        // Divide by 128 keeps the count still for long stretches, so reads are exact.
        wr(`OFF_TSC, 8'h0F);
        rng = xs(cur);
        // Let the count move first, so that the clear has something to undo.
        repeat (300) @(posedge core_clk);
        wr(`OFF_CNT_LO, rng[7:0]);
        repeat (60) @(posedge core_clk);
        rd(`OFF_CNT_LO, 8'h00);
        rd(`OFF_CNT_HI, 8'h00);
        rd(`OFF_CNT_HI, 8'h00);
        repeat (640) @(posedge core_clk);
        halt(1'b1);
        rd(`OFF_CNT_LO, 8'h05);
        repeat (300) @(posedge core_clk);
        rd(`OFF_CNT_LO, 8'h05);
        rd(`OFF_CNT_HI, 8'h00);
        wr(`OFF_MOD_HI, 8'h12);
        wr(`OFF_TSC, 8'h0F);
        halt(1'b0);
        // The low byte alone must not complete the pairing cleared in halt.
        wr(`OFF_MOD_LO, 8'h34);
        rd16(`OFF_MOD_HI, 16'h0000);
        rd(`OFF_CNT_HI, 8'h00);
        halt(1'b1);
        wr(`OFF_CNT_HI, rng[15:8]);
        halt(1'b0);
        rd(`OFF_CNT_LO, 8'h00);
        wr(`OFF_CNT_HI, 8'h00);
        nv = xs(rng);
        wr16(`OFF_CV_HI, nv);
        rd16(`OFF_CV_HI, cur);
        repeat (130) @(posedge core_clk);
        rd16(`OFF_CV_HI, nv);
        cur = nv;
        wr(`OFF_MOD_HI, 8'h00);
        wr(`OFF_MOD_LO, 8'h40);
        for (int k = 0; k < 2; k++) begin
            wr(`OFF_TSC, (k == 1) ? 8'h28 : 8'h08);
            wr(`OFF_CSC, (k == 1) ? 8'h06 : 8'h07);
            wr(`OFF_CNT_HI, 8'h00);
            rng = xs(rng);
            nv = {10'h000, rng[5:0]};
            wr16(`OFF_CV_HI, nv);
            rd16(`OFF_CV_HI, cur);
            repeat (70) @(posedge core_clk);
            rd16(`OFF_CV_HI, nv);
            check8("chan_oe", 8'h01, {7'h00, chan_oe});
            cur = nv;
        end
        duty(16'h0010, 30, 34);
        duty(16'h003F, 120, 127);
        duty(16'h0040, 128, 128);
        cur = 16'h0040;
        wr(`OFF_MOD_HI, 8'h00);
        wr(`OFF_MOD_LO, 8'h00);
        wr(`OFF_TSC, 8'h08);
        wr(`OFF_CSC, 8'h07);
        wr(`OFF_CNT_HI, 8'h00);
        wr16(`OFF_CV_HI, 16'h0021);
        repeat (1000) @(posedge core_clk);
        rd16(`OFF_CV_HI, cur);
        repeat (64600) @(posedge core_clk);
        rd16(`OFF_CV_HI, 16'h0021);
        results();
    end
endmodule
